// ===== rcf_defines.svh
`ifndef RCF_DEFINES_SVH
`define RCF_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RCF_OFS_ENABLE 8'h00
`define RCF_OFS_DISCHARGE 8'h04
`define RCF_OFS_UNMASK 8'h08
`define RCF_OFS_POWER_GOOD 8'h0c
`define RCF_OFS_FAULT 8'h10
`define RCF_OFS_IRQ_STATUS 8'h14
`define RCF_OFS_IRQ_CLEAR 8'h18
`define RCF_OFS_IRQ_ENABLE 8'h1c
`define RCF_OFS_LEVEL_FIRST 8'h20
`define RCF_OFS_LEVEL_LAST 8'h5c

// ****************************************************************
// Reset values
// ****************************************************************
`define RCF_RST_ENABLE 12'h000
`define RCF_RST_DISCHARGE 8'h00
`define RCF_RST_UNMASK 12'h000
`define RCF_RST_IRQ_ENABLE 12'h000
`define RCF_RST_LEVEL 6'h00

// ****************************************************************
// Output level decode and power-good margins
// ****************************************************************
// Column base voltages in mV, column 7 in the top field
`define RCF_COL_BASE_MV 96'hc80_960_7d0_640_4b0_3e8_320_258
// Step size in mV per column, column 7 in the top byte
`define RCF_COL_STEP_MV 64'h64_64_32_32_32_19_19_19
`define RCF_BUCK_PG_PCT 7'h07
`define RCF_LDO_PG_PCT 7'h0b
`define RCF_PCT_FULL 7'h64

`endif

// ===== rcf_pkg.sv
package rcf_pkg;

    // Per-rail control bundle driven toward the analog section
    typedef struct packed {
        logic enable;        // Regulator switched on
        logic discharge_on;  // Output pull-down resistor engaged
        logic [5:0] code;    // Active output_level_code
    } rcf_rail_type;

    // Decoded voltage pair for one rail
    typedef struct packed {
        logic [11:0] target_mv;  // Programmed output voltage
        logic [11:0] thresh_mv;  // Power-good threshold
    } rcf_level_type;

endpackage

// ===== rcf_sync2.sv
`timescale 1ns/100ps

module rcf_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q; // First stage, read only by the second
    logic [WIDTH-1:0] sync_q; // Second stage

    // Two flops per bit; pins are asynchronous to i_clock
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // rcf_sync2

// ===== rcf_level_decode.sv
`timescale 1ns/100ps
`include "rcf_defines.svh"

module rcf_level_decode #(
    parameter logic [6:0] PG_PCT = `RCF_BUCK_PG_PCT
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [5:0] i_code,
    output rcf_pkg::rcf_level_type o_level
);

    // ****************************************************************
    // Code to millivolts
    // ****************************************************************
    logic [2:0] col;        // Coarse column, upper code bits
    logic [2:0] step;       // Step in column, lower code bits
    logic [11:0] base_mv;   // Column base
    logic [7:0] step_mv;    // Column step size
    logic [11:0] target_d;
    logic [18:0] scaled;    // Target times remaining percentage
    logic [11:0] thresh_d;
    rcf_pkg::rcf_level_type level_q;

    // Table lookup then linear step within the column
    always_comb
    begin
        col = i_code[5:3];
        step = i_code[2:0];
        base_mv = 12'(`RCF_COL_BASE_MV >> (12 * col));
        step_mv = 8'(`RCF_COL_STEP_MV >> (8 * col));
        // Product widened first, a 100 mV step times 7 overflows a byte
        target_d = base_mv + 12'(12'(step_mv) * 12'(step));
        // Threshold sits the margin below target; truncation errs low
        scaled = 19'(target_d) * 19'(`RCF_PCT_FULL - PG_PCT);
        thresh_d = 12'(scaled / 19'(`RCF_PCT_FULL));
    end

    // Registered so the outputs are flop driven
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            level_q <= '0;
        else
            level_q <= '{target_mv: target_d, thresh_mv: thresh_d};
    end

    assign o_level = level_q;

endmodule // rcf_level_decode

// ===== rcf_regulator_ctrl.sv
// How it works
// - Buck runs while its enable bit set
// - Buck good bit 0 below 7% margin
// - Unmasked buck dropout raises host interrupt
// - Interrupt holds until recovered and good read
// - Code upper bits column, lower bits step
// - Rails start at default, host rewrites
// - Each rail follows its own level code
// - Linear regulator runs while enable set
// - Disabled linear rail discharged when enabled
// - Linear good bit 0 below 11% margin
// - Unmasked linear dropout raises host interrupt
// - Select pin picks low or high code
`timescale 1ns/100ps
`include "rcf_defines.svh"

module rcf_regulator_ctrl #(
    parameter int NUM_BUCK = 4,
    parameter int NUM_LDO = 8,
    parameter logic [3:0] SEL_MASK = 4'he,
    parameter logic [5:0] LEVEL_DEFAULT = `RCF_RST_LEVEL
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_level_select_pin,
    input wire logic [NUM_BUCK+NUM_LDO-1:0] i_pg_raw,
    output rcf_pkg::rcf_rail_type [NUM_BUCK+NUM_LDO-1:0] o_rail,
    output rcf_pkg::rcf_level_type [NUM_BUCK+NUM_LDO-1:0] o_level,
    output logic o_host_irq_n,
    output logic o_irq
);

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NREG = NUM_BUCK + NUM_LDO;  // Rails, bucks first
    localparam int NLVL = 2 * NUM_BUCK + NUM_LDO; // Level code slots

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NREG-1:0] pg_s;  // Comparator result, 1 = at or above
    logic sel_s;            // Synchronised level_select_pin

    rcf_sync2 #(
        .WIDTH(NREG)
    ) u_pg_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(i_pg_raw),
        .o_sync(pg_s)
    );

    rcf_sync2 #(
        .WIDTH(1)
    ) u_sel_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async(i_level_select_pin),
        .o_sync(sel_s)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [7:0] lvl_ofs;     // Offset into level code window
    logic lvl_hit;           // Address falls on a level code word
    logic [3:0] lvl_idx;     // Level slot addressed
    logic rd_pg;             // Host reads the power-good word

    always_comb
    begin
        lvl_ofs = i_addr - `RCF_OFS_LEVEL_FIRST;
        lvl_hit = (i_addr >= `RCF_OFS_LEVEL_FIRST) && (i_addr <= `RCF_OFS_LEVEL_LAST) && (i_addr[1:0] == 2'h0);
        lvl_idx = lvl_ofs[5:2];
        rd_pg = i_rd && (i_addr == `RCF_OFS_POWER_GOOD);
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [NREG-1:0] enable_q, enable_d;       // Per-rail on bits
    logic [NUM_LDO-1:0] dis_q, dis_d;          // discharge_enable bits
    logic [NREG-1:0] unmask_q, unmask_d;       // fault_irq_unmask bits
    logic [NREG-1:0] irq_en_q, irq_en_d;       // Interrupt enable mask
    logic [5:0] lvl_q [NLVL];                  // Stored level codes
    logic [5:0] lvl_d [NLVL];

    // Host writes; the low and high codes of bucks occupy slots
    // 0..NUM_BUCK-1 and NUM_BUCK..2*NUM_BUCK-1, linear rails follow
    always_comb
    begin
        enable_d = enable_q;
        dis_d = dis_q;
        unmask_d = unmask_q;
        irq_en_d = irq_en_q;
        lvl_d = lvl_q;
        if (i_wr)
        begin
            case (i_addr)
                `RCF_OFS_ENABLE:
                    enable_d = i_wdata[NREG-1:0];
                `RCF_OFS_DISCHARGE:
                    dis_d = i_wdata[NUM_LDO-1:0];
                `RCF_OFS_UNMASK:
                    unmask_d = i_wdata[NREG-1:0];
                `RCF_OFS_IRQ_ENABLE:
                    irq_en_d = i_wdata[NREG-1:0];
                default:
                begin
                    // Only the addressed slot changes
                    if (lvl_hit && (int'(lvl_idx) < NLVL))
                        lvl_d[lvl_idx] = i_wdata[5:0];
                end
            endcase
        end
    end

    // Register stage for control state
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            enable_q <= `RCF_RST_ENABLE;
            dis_q <= `RCF_RST_DISCHARGE;
            unmask_q <= `RCF_RST_UNMASK;
            irq_en_q <= `RCF_RST_IRQ_ENABLE;
            // Power-up value is the default output voltage
            for (int k = 0; k < NLVL; k++)
                lvl_q[k] <= LEVEL_DEFAULT;
        end
        else
        begin
            enable_q <= enable_d;
            dis_q <= dis_d;
            unmask_q <= unmask_d;
            irq_en_q <= irq_en_d;
            lvl_q <= lvl_d;
        end
    end

    // ****************************************************************
    // Rail outputs and level decode
    // ****************************************************************
    rcf_pkg::rcf_rail_type [NREG-1:0] rail_d, rail_q;

    genvar g;
    generate
        for (g = 0; g < NREG; g++)
        begin : g_rail
            if (g < NUM_BUCK)
            begin : g_buck
                // Selectable bucks take the high code while pin is high
                always_comb
                begin
                    rail_d[g].enable = enable_q[g];
                    rail_d[g].discharge_on = 1'b0;
                    if (SEL_MASK[g] && sel_s)
                        rail_d[g].code = lvl_q[NUM_BUCK+g];
                    else
                        rail_d[g].code = lvl_q[g];
                end

                // 7% margin for switching rails
                rcf_level_decode #(
                    .PG_PCT(`RCF_BUCK_PG_PCT)
                ) u_dec (
                    .i_clock(i_clock),
                    .i_rst(i_rst),
                    .i_code(rail_q[g].code),
                    .o_level(o_level[g])
                );
            end
            else
            begin : g_ldo
                // Pull-down only while disabled and permitted
                always_comb
                begin
                    rail_d[g].enable = enable_q[g];
                    rail_d[g].discharge_on = dis_q[g-NUM_BUCK] & ~enable_q[g];
                    rail_d[g].code = lvl_q[NUM_BUCK+g];
                end

                // 11% margin for linear rails
                rcf_level_decode #(
                    .PG_PCT(`RCF_LDO_PG_PCT)
                ) u_dec (
                    .i_clock(i_clock),
                    .i_rst(i_rst),
                    .i_code(rail_q[g].code),
                    .o_level(o_level[g])
                );
            end
        end
    endgenerate

    // Rail bundle register; the select pin takes effect here
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < NREG; k++)
                rail_q[k] <= '{enable: 1'b0, discharge_on: 1'b0, code: LEVEL_DEFAULT};
        end
        else
            rail_q <= rail_d;
    end

    assign o_rail = rail_q;

    // ****************************************************************
    // Fault detection and interrupt
    // ****************************************************************
    logic [NREG-1:0] pg_prev_q, pg_prev_d;   // Good level one cycle ago
    logic [NREG-1:0] fault_q, fault_d;       // Pending fault per rail
    logic [NREG-1:0] seen_q, seen_d;         // Good bit read since fault
    logic [NREG-1:0] stat_q, stat_d;         // Sticky fault events
    logic [NREG-1:0] fault_evt;              // Dropout on unmasked rail
    logic [NREG-1:0] recovered;              // Off or back in regulation

    // A good to bad transition is used rather than the level, so a
    // rail ramping in soft start does not trip the interrupt.
    // Limitation: a rail that never reached good after enable can
    // not raise the line; software must poll its good bit instead.
    // The previous sample resets to 0, so no false edge follows
    // reset even though the synchronisers also start at 0.
    always_comb
    begin
        pg_prev_d = pg_s;
        fault_evt = unmask_q & enable_q & pg_prev_q & ~pg_s;
        recovered = ~enable_q | pg_s;
        // A read only counts after the fault it answers
        seen_d = (seen_q | (rd_pg ? fault_q : '0)) & ~fault_evt;
        // New event wins over release in the same cycle
        fault_d = fault_evt | (fault_q & ~(seen_q & recovered));
        stat_d = fault_evt | (stat_q & ~((i_wr && (i_addr == `RCF_OFS_IRQ_CLEAR)) ? i_wdata[NREG-1:0] : '0));
    end

    // Register stage for fault state
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            pg_prev_q <= '0;
            fault_q <= '0;
            seen_q <= '0;
            stat_q <= '0;
        end
        else
        begin
            pg_prev_q <= pg_prev_d;
            fault_q <= fault_d;
            seen_q <= seen_d;
            stat_q <= stat_d;
        end
    end

    // Line low while any fault is pending.
    // The line is not gated by the interrupt enable mask; that mask
    // only steers the sticky status onto the level output o_irq.
    // Both outputs come from flops or a gate over flops, so they
    // never glitch on a bus access.
    assign o_host_irq_n = ~|fault_q;
    assign o_irq = |(stat_q & irq_en_q);

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [31:0] rdata_d, rdata_q;   // Answer in the cycle after i_rd

    // Unmapped and write-only words read as zero.
    // Reading the good word is what releases a pending fault; the fault
    // logic above uses rd_pg, while this mux decodes that address itself.
    // The answer is zero outside the read cycle, which keeps a shared
    // return bus quiet without an extra enable.
    always_comb
    begin
        rdata_d = '0;
        if (i_rd)
        begin
            case (i_addr)
                `RCF_OFS_ENABLE:
                    rdata_d[NREG-1:0] = enable_q;
                `RCF_OFS_DISCHARGE:
                    rdata_d[NUM_LDO-1:0] = dis_q;
                `RCF_OFS_UNMASK:
                    rdata_d[NREG-1:0] = unmask_q;
                `RCF_OFS_POWER_GOOD:
                    rdata_d[NREG-1:0] = pg_s;
                `RCF_OFS_FAULT:
                    rdata_d[NREG-1:0] = fault_q;
                `RCF_OFS_IRQ_STATUS:
                    rdata_d[NREG-1:0] = stat_q;
                `RCF_OFS_IRQ_ENABLE:
                    rdata_d[NREG-1:0] = irq_en_q;
                default:
                begin
                    if (lvl_hit && (int'(lvl_idx) < NLVL))
                        rdata_d[5:0] = lvl_q[lvl_idx];
                end
            endcase
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign o_rdata = rdata_q;

endmodule // rcf_regulator_ctrl

// ===== rcf_ctrl_assertions.sv
`timescale 1ns/100ps
`include "rcf_defines.svh"

// ****************************************************************
// Port checker for the regulator control block
// ****************************************************************
module rcf_ctrl_assertions #(
    parameter int NUM_BUCK = 4,
    parameter int NUM_LDO = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_level_select_pin,
    input wire logic [NUM_BUCK+NUM_LDO-1:0] i_pg_raw,
    input rcf_pkg::rcf_rail_type [NUM_BUCK+NUM_LDO-1:0] o_rail,
    input rcf_pkg::rcf_level_type [NUM_BUCK+NUM_LDO-1:0] o_level,
    input wire logic o_host_irq_n,
    input wire logic o_irq
);
    // Column base and step in mV, indexed by the upper code bits
    localparam logic [11:0] BASE [8] = '{12'h258, 12'h320, 12'h3e8, 12'h4b0, 12'h640, 12'h7d0, 12'h960, 12'hc80};
    localparam logic [11:0] STEP [8] = '{12'h19, 12'h19, 12'h19, 12'h32, 12'h32, 12'h32, 12'h64, 12'h64};
    logic read_seen_q; // Good-status read while the line is low

    function automatic logic [11:0] mv(input logic [5:0] c);
        return BASE[c[5:3]] + STEP[c[5:3]] * c[2:0];
    endfunction

    // Cleared while the line is high, so only reads during a fault count
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
            read_seen_q <= 1'b0;
        else if (o_host_irq_n)
            read_seen_q <= 1'b0;
        else if (i_rd && i_addr == `RCF_OFS_POWER_GOOD)
            read_seen_q <= 1'b1;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    buck_enable_a: assert property (
        i_wr && i_addr == `RCF_OFS_ENABLE |=> ##1 o_rail[0].enable == $past(i_wdata[0], 2))
        else $error("buck enable mismatch");
    ldo_enable_a: assert property (
        i_wr && i_addr == `RCF_OFS_ENABLE |=> ##1 o_rail[4].enable == $past(i_wdata[4], 2))
        else $error("linear enable mismatch");
    discharge_gate_a: assert property (o_rail[4].enable |-> !o_rail[4].discharge_on)
        else $error("discharge on an enabled rail");
    code_follow_a: assert property (
        i_wr && i_addr == 8'h40 |=> ##1 o_rail[4].code == $past(i_wdata[5:0], 2))
        else $error("level code not applied");
    target_decode_a: assert property (
        !$past(i_rst) |-> o_level[4].target_mv == mv($past(o_rail[4].code)))
        else $error("target decode wrong");
    buck_thresh_a: assert property (
        o_level[1].thresh_mv == 12'(32'(o_level[1].target_mv) * 32'h5d / 32'h64))
        else $error("buck threshold wrong");
    ldo_thresh_a: assert property (
        o_level[4].thresh_mv == 12'(32'(o_level[4].target_mv) * 32'h59 / 32'h64))
        else $error("linear threshold wrong");
    irq_raise_a: assert property (
        $fell(o_host_irq_n) |-> ($past(i_pg_raw, 4) & ~$past(i_pg_raw, 3)) != '0)
        else $error("interrupt without a dropout");
    irq_hold_a: assert property ($rose(o_host_irq_n) |-> read_seen_q)
        else $error("interrupt released without a read");
    pg_read_a: assert property (
        $past(i_rd && i_addr == `RCF_OFS_POWER_GOOD) && $past(i_pg_raw, 2) == $past(i_pg_raw, 4)
        |-> o_rdata == 32'($past(i_pg_raw, 3)))
        else $error("good status read wrong");

    cover property ($fell(o_host_irq_n));
    cover property ($rose(o_host_irq_n));
    cover property (o_rail[5].discharge_on);
endmodule // rcf_ctrl_assertions

bind rcf_regulator_ctrl rcf_ctrl_assertions #(.NUM_BUCK(NUM_BUCK), .NUM_LDO(NUM_LDO)) u_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_level_select_pin(i_level_select_pin), .i_pg_raw(i_pg_raw), .o_rail(o_rail),
    .o_level(o_level), .o_host_irq_n(o_host_irq_n), .o_irq(o_irq));

// ===== rcf_rail_model.sv
`timescale 1ns/100ps

// ****************************************************************
// Rail comparators: good once enabled, low when a dropout is forced
// ****************************************************************
module rcf_rail_model (
    input wire logic i_clock,
    input rcf_pkg::rcf_rail_type [11:0] i_rail,
    input wire logic [11:0] i_drop,
    output logic [11:0] o_pg
);
    initial o_pg = 12'h000;

    // A disabled rail never reports good
    always @(posedge i_clock)
    begin
        for (int r = 0; r < 12; r++)
            o_pg[r] <= i_rail[r].enable & ~i_drop[r];
    end
endmodule // rcf_rail_model

// ===== testbench.sv
`timescale 1ns/100ps
`include "rcf_defines.svh"

module testbench;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_level_select_pin = 1'b0;
    logic [11:0] drop = 12'h000; // Forced dropouts per rail
    logic [11:0] pg;
    logic [31:0] o_rdata;
    rcf_pkg::rcf_rail_type [11:0] o_rail;
    rcf_pkg::rcf_level_type [11:0] o_level;
    logic o_host_irq_n;
    logic o_irq;
    int n_fail = 0;
    int checked = 0;

    always #2.5 i_clock = ~i_clock;

    rcf_regulator_ctrl uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_level_select_pin(i_level_select_pin),
        .i_pg_raw(pg), .o_rail(o_rail), .o_level(o_level), .o_host_irq_n(o_host_irq_n), .o_irq(o_irq));
    rcf_rail_model rail_model (.i_clock(i_clock), .i_rail(o_rail), .i_drop(drop), .o_pg(pg));

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic set_drop(input logic [11:0] d);
        @(posedge i_clock);
        drop <= d;
    endtask

    task automatic wait_irq(input logic v);
        for (int k = 0; k < 10 && o_host_irq_n !== v; k++)
            @(posedge i_clock);
        #1 chk(o_host_irq_n, v);
    endtask

    task automatic report_and_stop;
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog well beyond the roughly 120 cycles of the tests
    initial
    begin
        repeat (3000) @(posedge i_clock);
        n_fail++;
        report_and_stop;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        cyc(2);
        chk(o_host_irq_n, 1'b1);
        chk(o_rail[0], 8'h00);
        chk(o_level[0], {12'h258, 12'h22e});
        wr(`RCF_OFS_ENABLE, 32'h013);
        cyc(2);
        chk(o_rail[0].enable, 1'b1);
        chk(o_rail[2].enable, 1'b0);
        chk(o_rail[4].enable, 1'b1);
        cyc(2);
        rd(`RCF_OFS_POWER_GOOD, 32'h013);
        wr(`RCF_OFS_DISCHARGE, 32'h03);
        cyc(2);
        chk(o_rail[5].discharge_on, 1'b1);
        chk(o_rail[4].discharge_on, 1'b0);
        wr(8'h40, 32'h3f);
        cyc(3);
        chk(o_level[4], {12'hf3c, 12'hd8f});
        chk(o_rail[0].code, 6'h00);
        wr(8'h34, 32'h1a);
        cyc(3);
        chk(o_rail[1].code, 6'h00);
        @(posedge i_clock);
        i_level_select_pin <= 1'b1;
        cyc(6);
        chk(o_level[1], {12'h514, 12'h4b9});
        chk(o_rail[0].code, 6'h00);
        wr(`RCF_OFS_UNMASK, 32'h011);
        wr(`RCF_OFS_IRQ_ENABLE, 32'h001);
        set_drop(12'h002);
        cyc(8);
        chk(o_host_irq_n, 1'b1);
        set_drop(12'h003);
        wait_irq(1'b0);
        chk(o_irq, 1'b1);
        rd(`RCF_OFS_IRQ_STATUS, 32'h001);
        rd(`RCF_OFS_POWER_GOOD, 32'h010);
        cyc(4);
        chk(o_host_irq_n, 1'b0);
        set_drop(12'h002);
        cyc(6);
        chk(o_host_irq_n, 1'b1);
        set_drop(12'h012);
        wait_irq(1'b0);
        set_drop(12'h002);
        cyc(8);
        chk(o_host_irq_n, 1'b0);
        rd(`RCF_OFS_POWER_GOOD, 32'h011);
        cyc(3);
        chk(o_host_irq_n, 1'b1);
        wr(`RCF_OFS_IRQ_CLEAR, 32'hfff);
        cyc(1);
        chk(o_irq, 1'b0);
        rd(`RCF_OFS_IRQ_STATUS, 32'h0);
        rd(8'h80, 32'h0);
        wr(`RCF_OFS_ENABLE, 32'h003);
        cyc(2);
        chk(o_rail[4].discharge_on, 1'b1);
        rd(`RCF_OFS_ENABLE, 32'h003);
        report_and_stop;
    end
endmodule // testbench
